/* hdl/fspd_cmd_core.sv */
// Notes on behaviour
// - Read opcodes select status byte 0,1,2
// - Status reads allowed unless asleep or locked out, repeat while clocked
// - Status write needs write enable latch or volatile enable set
// - Write opcodes load status byte 0,1,2
// - Status bits 20,19,16,13,1,0 never written
// - Status write only on exact byte boundary
// - Write with latch set runs timed cycle, clears latch
// - Protect bit with pin low refuses writes
// - Block protect bits size read-only region
// - Sleep only via B9, blocks writes
// - Asleep, only wake or reset pair act
// - Sleep on exact opcode frame after delay
// - Sleep command refused while cycle runs
// - Powers up awake; deselect while idle and awake means standby
// - Bare wake locks out commands for wake_time
// - Wake with three dummies streams device ID
// - ID-form wake locks out for shorter time
// - Wake command ignored while cycle runs
// - Reset aborts, clears volatile state and settings
// - Reset pair in separate frames, nothing between while awake
// - Commands refused during reset recovery
`default_nettype none
module fspd_cmd_core
  import fspd_pkg::*;
#(
  parameter int unsigned WRT_CYC = WRT_CYC_DEF,
  parameter int unsigned TRST_CYC = TRST_CYC_DEF
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_si,
  output logic spi_so,
  output logic spi_so_oe,
  input wire logic wp_n,
  input wire logic array_busy,
  input wire logic param_load,
  input wire logic [7:0] param_in,
  input wire logic [2:0] wrap_in,
  output logic [23:0] status_word,
  output logic write_enable_latch,
  output logic cycle_in_progress,
  output logic [4:0] block_protect_field,
  output logic status_protect_bit,
  output logic deep_sleep,
  output logic standby,
  output logic [7:0] read_parameter_bits,
  output logic [2:0] wrap_setting_bits,
  output logic soft_reset_pulse
);

  // ----------------------------------------
  // Link synchroniser
  // ----------------------------------------
  fspd_link_type link; // Synced pins and clock edges

  fspd_link_sync u_sync (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .spi_sclk(spi_sclk),
    .spi_cs_n(spi_cs_n),
    .spi_si(spi_si),
    .wp_n(wp_n),
    .link(link)
  );

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  fspd_frame_type frame_q, frame_d; // Frame phase
  logic [2:0] bitcnt_q, bitcnt_d; // Bits within current byte
  logic [2:0] bytecnt_q, bytecnt_d; // Whole bytes, saturating
  logic [7:0] shift_q, shift_d; // Incoming shift register
  logic [7:0] opcode_q, opcode_d; // First byte of frame
  logic [7:0] data_q, data_d; // Second byte of frame
  logic [7:0] hold_q, hold_d; // Byte being shifted out
  logic [2:0] ocnt_q, ocnt_d; // Output bit index
  logic [1:0] rsel_q, rsel_d; // Output source
  logic so_q, so_d; // Output data bit
  logic cs_old_q, cs_old_d; // Previous chip select

  logic [23:0] live_q, live_d; // Active status contents
  logic [23:0] nv_q, nv_d; // Non-volatile copy
  logic wen_q, wen_d; // write_enable_latch
  logic vol_en_q, vol_en_d; // Volatile write enable
  logic prg_q, prg_d; // cycle_in_progress
  logic [TMR_W-1:0] cyc_q, cyc_d; // Status write timer
  logic [TMR_W-1:0] lock_q, lock_d; // Command refusal timer
  logic pend_q, pend_d; // Sleep entry pending
  logic sleep_q, sleep_d; // Deep sleep state
  logic rst_en_q, rst_en_d; // Reset enable armed
  logic [7:0] param_q, param_d; // read_parameter_bits
  logic [2:0] wrap_q, wrap_d; // wrap_setting_bits
  logic srst_q, srst_d; // Soft reset pulse

  logic [7:0] rx_byte; // Byte with current bit appended
  logic [23:0] view; // Status as read back
  logic [7:0] out_src; // Byte chosen for output
  logic frame_end; // Chip select rising
  logic locked; // Commands refused
  logic busy; // Any internal cycle running
  logic hw_prot; // Hardware protected mode
  logic [1:0] wslot; // Write opcode byte index
  logic [23:0] wr_val; // Status after masked write

  // ----------------------------------------
  // Shared terms
  // ----------------------------------------
  always_comb begin
    rx_byte = {shift_q[6:0], link.si};
    view = live_q;
    view[SR_PRG] = prg_q;
    view[SR_WEN] = wen_q;
    out_src = (rsel_q == SLOT_NONE) ? DEV_ID : view[rsel_q*8 +: 8];
    frame_end = link.cs_n & ~cs_old_q;
    locked = (lock_q != '0);
    busy = prg_q | array_busy;
    hw_prot = live_q[SR_SPB] & ~link.wp_n;
    wslot = fspd_write_slot(opcode_q);
    wr_val = live_q;
    if (wslot != SLOT_NONE) begin
      wr_val[wslot*8 +: 8] = data_q;
    end
    wr_val = (live_q & SR_FIXED) | (wr_val & ~SR_FIXED);
  end

  // ----------------------------------------
  // Frame shifter: next values
  // ----------------------------------------
  always_comb begin
    frame_d = frame_q;
    bitcnt_d = bitcnt_q;
    bytecnt_d = bytecnt_q;
    shift_d = shift_q;
    opcode_d = opcode_q;
    data_d = data_q;
    hold_d = hold_q;
    ocnt_d = ocnt_q;
    rsel_d = rsel_q;
    so_d = so_q;
    cs_old_d = link.cs_n;
    if (link.cs_n) begin
      // Deselected: clear counters for the next frame
      frame_d = FR_IDLE;
      bitcnt_d = 3'h0;
      bytecnt_d = 3'h0;
      ocnt_d = 3'h0;
      so_d = 1'b0;
    end else begin
      if (frame_q == FR_IDLE) begin
        frame_d = FR_CMD;
      end
      if (link.rise && frame_q != FR_IDLE) begin
        shift_d = rx_byte;
        bitcnt_d = bitcnt_q + 3'h1;
        if (bitcnt_q == BIT_LAST) begin
          if (bytecnt_q != BYTE_SAT) begin
            bytecnt_d = bytecnt_q + 3'h1;
          end
          unique case (frame_q)
            FR_CMD: begin
              opcode_d = rx_byte;
              frame_d = FR_DATA;
              if (!locked && !sleep_q && fspd_read_slot(rx_byte) != SLOT_NONE) begin
                frame_d = FR_OUT;
                rsel_d = fspd_read_slot(rx_byte);
              end else if (!locked && !busy && rx_byte == OP_WAKE) begin
                frame_d = FR_DUMMY;
              end
            end
            FR_DATA: begin
              if (bytecnt_q == 3'h1) begin
                data_d = rx_byte;
              end
            end
            FR_DUMMY: begin
              if (bytecnt_q == ID_LAST_DUMMY) begin
                frame_d = FR_OUT;
                rsel_d = SLOT_NONE;
              end
            end
            FR_IDLE, FR_OUT: begin
            end
          endcase
        end
      end
      if (link.fall && frame_q == FR_OUT) begin
        ocnt_d = ocnt_q + 3'h1;
        if (ocnt_q == 3'h0) begin
          // Latch whole byte so a mid-byte status change cannot tear it
          hold_d = out_src;
          so_d = out_src[7];
        end else begin
          so_d = hold_q[~ocnt_q];
        end
      end
    end
  end

  // Frame shifter registers
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      frame_q <= FR_IDLE;
      bitcnt_q <= 3'h0;
      bytecnt_q <= 3'h0;
      shift_q <= 8'h00;
      opcode_q <= 8'h00;
      data_q <= 8'h00;
      hold_q <= 8'h00;
      ocnt_q <= 3'h0;
      rsel_q <= 2'h0;
      so_q <= 1'b0;
      cs_old_q <= 1'b1;
    end else begin
      frame_q <= frame_d;
      bitcnt_q <= bitcnt_d;
      bytecnt_q <= bytecnt_d;
      shift_q <= shift_d;
      opcode_q <= opcode_d;
      data_q <= data_d;
      hold_q <= hold_d;
      ocnt_q <= ocnt_d;
      rsel_q <= rsel_d;
      so_q <= so_d;
      cs_old_q <= cs_old_d;
    end
  end

  // ----------------------------------------
  // Command execution: next values
  // ----------------------------------------
  always_comb begin
    live_d = live_q;
    nv_d = nv_q;
    wen_d = wen_q;
    vol_en_d = vol_en_q;
    prg_d = prg_q;
    cyc_d = cyc_q;
    lock_d = lock_q;
    pend_d = pend_q;
    sleep_d = sleep_q;
    rst_en_d = rst_en_q;
    param_d = param_q;
    wrap_d = wrap_q;
    srst_d = 1'b0;
    // Settings loaded by neighbouring command logic
    if (param_load) begin
      param_d = param_in;
      wrap_d = wrap_in;
    end
    if (prg_q) begin
      cyc_d = cyc_q - TMR_ONE;
      if (cyc_q == TMR_ONE) begin
        prg_d = 1'b0;
        wen_d = 1'b0;
      end
    end
    // Refusal window; a pending sleep lands when it runs out
    if (locked) begin
      lock_d = lock_q - TMR_ONE;
      if (lock_q == TMR_ONE && pend_q) begin
        pend_d = 1'b0;
        sleep_d = 1'b1;
      end
    end
    if (frame_end && bytecnt_q != 3'h0 && !locked) begin
      if (!sleep_q || opcode_q == OP_WAKE) begin
        rst_en_d = 1'b0;
      end
      unique case (opcode_q)
        OP_RST_EN: begin
          rst_en_d = fspd_exact(bytecnt_q, bitcnt_q, 3'h1);
        end
        OP_RST: begin
          rst_en_d = 1'b0;
          if (rst_en_q && fspd_exact(bytecnt_q, bitcnt_q, 3'h1)) begin
            live_d = nv_q;
            wen_d = 1'b0;
            vol_en_d = 1'b0;
            prg_d = 1'b0;
            cyc_d = '0;
            pend_d = 1'b0;
            sleep_d = 1'b0;
            param_d = 8'h00;
            wrap_d = 3'h0;
            srst_d = 1'b1;
            lock_d = TMR_W'(TRST_CYC);
          end
        end
        OP_WAKE: begin
          if (!busy && sleep_q) begin
            if (fspd_exact(bytecnt_q, bitcnt_q, 3'h1)) begin
              sleep_d = 1'b0;
              lock_d = WAKE_CYC;
            end else if (bytecnt_q > ID_LAST_DUMMY) begin
              sleep_d = 1'b0;
              lock_d = WAKID_CYC;
            end
          end
        end
        default: begin
          if (!sleep_q) begin
            if (opcode_q == OP_WEN && fspd_exact(bytecnt_q, bitcnt_q, 3'h1)) begin
              wen_d = 1'b1;
            end
            if (opcode_q == OP_VWREN && fspd_exact(bytecnt_q, bitcnt_q, 3'h1)) begin
              vol_en_d = 1'b1;
            end
            if (opcode_q == OP_SLEEP && !busy
                && fspd_exact(bytecnt_q, bitcnt_q, 3'h1)) begin
              pend_d = 1'b1;
              lock_d = SLP_CYC;
            end
            if (wslot != SLOT_NONE && fspd_exact(bytecnt_q, bitcnt_q, 3'h2)
                && (wen_q || vol_en_q) && !hw_prot && !busy) begin
              live_d = wr_val;
              vol_en_d = 1'b0;
              if (wen_q) begin
                nv_d = wr_val;
                prg_d = 1'b1;
                cyc_d = TMR_W'(WRT_CYC);
              end
            end
          end
        end
      endcase
    end
  end

  // Execution registers; power-on is always awake
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      live_q <= SR_RESET;
      nv_q <= SR_RESET;
      wen_q <= 1'b0;
      vol_en_q <= 1'b0;
      prg_q <= 1'b0;
      cyc_q <= '0;
      lock_q <= '0;
      pend_q <= 1'b0;
      sleep_q <= 1'b0;
      rst_en_q <= 1'b0;
      param_q <= 8'h00;
      wrap_q <= 3'h0;
      srst_q <= 1'b0;
    end else begin
      live_q <= live_d;
      nv_q <= nv_d;
      wen_q <= wen_d;
      vol_en_q <= vol_en_d;
      prg_q <= prg_d;
      cyc_q <= cyc_d;
      lock_q <= lock_d;
      pend_q <= pend_d;
      sleep_q <= sleep_d;
      rst_en_q <= rst_en_d;
      param_q <= param_d;
      wrap_q <= wrap_d;
      srst_q <= srst_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  always_comb begin
    spi_so = so_q;
    spi_so_oe = (frame_q == FR_OUT);
    status_word = view;
    write_enable_latch = wen_q;
    cycle_in_progress = prg_q;
    block_protect_field = live_q[SR_BP_LSB +: SR_BP_W];
    status_protect_bit = live_q[SR_SPB];
    deep_sleep = sleep_q;
    standby = link.cs_n & ~busy & ~sleep_q;
    read_parameter_bits = param_q;
    wrap_setting_bits = wrap_q;
    soft_reset_pulse = srst_q;
  end

endmodule
`default_nettype wire

/* hdl/fspd_link_sync.sv */
`default_nettype none
module fspd_link_sync
  import fspd_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_si,
  input wire logic wp_n,
  output fspd_link_type link
);

  // ----------------------------------------
  // Two-stage synchroniser plus edge stage
  // ----------------------------------------
  logic [3:0] meta_q; // First stage, read by stage two only
  logic [3:0] meta_d;
  logic [3:0] sync_q; // Second stage {sclk, cs_n, si, wp_n}
  logic [3:0] sync_d;
  logic sclk_old_q; // Previous synced clock for edge finding
  logic sclk_old_d;

  // Next values
  always_comb begin
    meta_d = {spi_sclk, spi_cs_n, spi_si, wp_n};
    sync_d = meta_q;
    sclk_old_d = sync_q[3];
  end

  // Registers; idle levels keep the device deselected
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      meta_q <= 4'h5;
      sync_q <= 4'h5;
      sclk_old_q <= 1'b0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      sclk_old_q <= sclk_old_d;
    end
  end

  // Data and clock share the same delay, so si is aligned with rise
  always_comb begin
    link.cs_n = sync_q[2];
    link.rise = sync_q[3] & ~sclk_old_q;
    link.fall = ~sync_q[3] & sclk_old_q;
    link.si = sync_q[1];
    link.wp_n = sync_q[0];
  end

endmodule
`default_nettype wire

/* inc/fspd_pkg.sv */
`default_nettype none
package fspd_pkg;

  // ----------------------------------------
  // Opcodes
  // ----------------------------------------
  localparam logic [7:0] OP_RD_S0 = 8'h05; // Status bits 7..0 out
  localparam logic [7:0] OP_RD_S1 = 8'h35; // Status bits 15..8 out
  localparam logic [7:0] OP_RD_S2 = 8'h15; // Status bits 23..16 out
  localparam logic [7:0] OP_WR_S0 = 8'h01; // Status bits 7..0 in
  localparam logic [7:0] OP_WR_S1 = 8'h31; // Status bits 15..8 in
  localparam logic [7:0] OP_WR_S2 = 8'h11; // Status bits 23..16 in
  localparam logic [7:0] OP_WEN = 8'h06; // write_enable_cmd
  localparam logic [7:0] OP_VWREN = 8'h50; // Volatile status write enable
  localparam logic [7:0] OP_SLEEP = 8'hB9; // deep_sleep_cmd
  localparam logic [7:0] OP_WAKE = 8'hAB; // wake_and_id_cmd
  localparam logic [7:0] OP_RST_EN = 8'h66; // Reset enable
  localparam logic [7:0] OP_RST = 8'h99; // Reset

  // ----------------------------------------
  // Status layout and values
  // ----------------------------------------
  localparam int SR_PRG = 0; // cycle_in_progress
  localparam int SR_WEN = 1; // write_enable_latch
  localparam int SR_BP_LSB = 2; // block_protect_field low bit
  localparam int SR_BP_W = 5; // block_protect_field width
  localparam int SR_SPB = 7; // status_protect_bit
  localparam logic [23:0] SR_FIXED = 24'h19_2003; // Bits 20,19,16,13,1,0
  localparam logic [23:0] SR_RESET = 24'h00_0000; // Power-on contents
  localparam logic [7:0] DEV_ID = 8'h5A; // Arbitrary neutral device ID

  // ----------------------------------------
  // Frame counting
  // ----------------------------------------
  localparam logic [2:0] BIT_LAST = 3'h7; // Eighth bit of a byte
  localparam logic [2:0] BYTE_SAT = 3'h7; // Byte counter ceiling
  localparam logic [2:0] ID_LAST_DUMMY = 3'h3; // Opcode plus three dummies done
  localparam logic [1:0] SLOT_NONE = 2'h3; // No status byte / ID source

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int TMR_W = 20; // Timer width
  localparam int CLK_NS = 5; // clk_sys period
  localparam int WRT_NS = 5000000; // status_write_time
  localparam int SLP_NS = 3000; // sleep_entry_time
  localparam int WAKE_NS = 3000; // wake_time
  localparam int WAKID_NS = 1800; // wake_with_id_time
  localparam int TRST_NS = 30000; // Reset recovery
  localparam int WRT_CYC_DEF = (WRT_NS + CLK_NS - 1) / CLK_NS;
  localparam int TRST_CYC_DEF = (TRST_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [TMR_W-1:0] SLP_CYC = TMR_W'((SLP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [TMR_W-1:0] WAKE_CYC = TMR_W'((WAKE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [TMR_W-1:0] WAKID_CYC = TMR_W'((WAKID_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [TMR_W-1:0] TMR_ONE = TMR_W'(1);

  // ----------------------------------------
  // Types
  // ----------------------------------------
  // Synchronised link view
  typedef struct packed {
    logic cs_n;
    logic rise;
    logic fall;
    logic si;
    logic wp_n;
  } fspd_link_type;

  // Frame phase, one-hot
  typedef enum logic [4:0] {
    FR_IDLE = 5'h01,
    FR_CMD = 5'h02,
    FR_DATA = 5'h04,
    FR_DUMMY = 5'h08,
    FR_OUT = 5'h10
  } fspd_frame_type;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Status byte index of a read opcode
  function automatic logic [1:0] fspd_read_slot(input logic [7:0] op);
    unique case (op)
      OP_RD_S0: fspd_read_slot = 2'h0;
      OP_RD_S1: fspd_read_slot = 2'h1;
      OP_RD_S2: fspd_read_slot = 2'h2;
      default: fspd_read_slot = SLOT_NONE;
    endcase
  endfunction

  // Status byte index of a write opcode
  function automatic logic [1:0] fspd_write_slot(input logic [7:0] op);
    unique case (op)
      OP_WR_S0: fspd_write_slot = 2'h0;
      OP_WR_S1: fspd_write_slot = 2'h1;
      OP_WR_S2: fspd_write_slot = 2'h2;
      default: fspd_write_slot = SLOT_NONE;
    endcase
  endfunction

  // Frame ended exactly after n whole bytes
  function automatic logic fspd_exact(input logic [2:0] bytes, input logic [2:0] bits,
                                      input logic [2:0] n);
    fspd_exact = (bytes == n) && (bits == 3'h0);
  endfunction

endpackage
`default_nettype wire

/* test/fspd_cmd_core_assertions.sv */
`default_nettype none
module fspd_cmd_core_assertions
  import fspd_pkg::*;
#(
  parameter int unsigned WRT_CYC = WRT_CYC_DEF
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic spi_cs_n,
  input wire logic spi_so,
  input wire logic spi_so_oe,
  input wire logic [23:0] status_word,
  input wire logic write_enable_latch,
  input wire logic cycle_in_progress,
  input wire logic deep_sleep,
  input wire logic standby,
  input wire logic [7:0] read_parameter_bits,
  input wire logic [2:0] wrap_setting_bits,
  input wire logic soft_reset_pulse
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // Cycles the timed write has run so far
  logic [31:0] run_q;
  logic [31:0] run_d;
  always_comb begin
    run_d = cycle_in_progress ? run_q + 32'h0000_0001 : 32'h0000_0000;
  end
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      run_q <= 32'h0000_0000;
    end else begin
      run_q <= run_d;
    end
  end
  sequence s_cyc_start;
    $rose(cycle_in_progress);
  endsequence
  // Natural end only: a reset abort drops the bit in the cycle of its own pulse
  sequence s_cyc_end;
    $fell(cycle_in_progress) && !soft_reset_pulse;
  endsequence
  a_cycle_too_short: assert property (s_cyc_end |-> run_q >= WRT_CYC - 1)
    else $error("timed cycle ended early");
  a_cycle_too_long: assert property (run_q <= WRT_CYC + 1)
    else $error("timed cycle overran");
  a_cycle_needs_latch: assert property (s_cyc_start |-> write_enable_latch)
    else $error("timed cycle without latch");
  a_latch_drops_end: assert property (s_cyc_end |-> ##[0:1] !write_enable_latch)
    else $error("latch kept after cycle");
  a_oe_after_cs: assert property (spi_cs_n [*8] |-> !spi_so_oe)
    else $error("output driven while deselected");
  a_so_idle_low: assert property (!spi_so_oe |-> !spi_so)
    else $error("data out not low when idle");
  a_fixed_bits: assert property ((status_word & 24'h19_2000) == 24'h00_0000)
    else $error("fixed status bit changed");
  a_reset_pulse: assert property (soft_reset_pulse |=> !soft_reset_pulse)
    else $error("reset pulse too long");
  a_reset_clears: assert property (soft_reset_pulse |-> ##[0:2] (!write_enable_latch
    && !deep_sleep && read_parameter_bits == 8'h00 && wrap_setting_bits == 3'h0))
    else $error("reset left state behind");
  a_sleep_stby: assert property (deep_sleep && $past(deep_sleep) |-> !standby)
    else $error("standby while asleep");
endmodule
`default_nettype wire

/* test/fspd_cmd_core_bench.sv */
`default_nettype none
`define CHK(nm, ex, got) begin \
  n_checks++; \
  if ((got) !== (ex)) begin \
    fail_count++; \
    $display("BAD %s expected %0h seen %0h", nm, ex, got); \
  end \
end
module fspd_cmd_core_bench
  import fspd_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [7:0] WOP [3] = '{OP_WR_S0, OP_WR_S1, OP_WR_S2};
  localparam logic [7:0] ROP [3] = '{OP_RD_S0, OP_RD_S1, OP_RD_S2};
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic wp_n = 1'b1;
  logic array_busy = 1'b0;
  logic param_load = 1'b0;
  logic [7:0] param_in = 8'h00;
  logic [2:0] wrap_in = 3'h0;
  logic spi_sclk, spi_cs_n, spi_si, spi_so, spi_so_oe, write_enable_latch;
  logic cycle_in_progress, status_protect_bit, deep_sleep, standby, soft_reset_pulse;
  logic [23:0] status_word;
  logic [4:0] block_protect_field;
  logic [7:0] read_parameter_bits;
  logic [2:0] wrap_setting_bits;
  logic [63:0] rx;
  logic [23:0] sr = 24'h00_0000;
  logic [7:0] d;
  int fail_count = 0;
  int n_checks = 0;
  int rst_seen = 0;
  always #2.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (soft_reset_pulse === 1'b1) rst_seen++;
  fspd_cmd_core #(.WRT_CYC(2000), .TRST_CYC(400)) i_fspd_cmd_core (.clk_sys(clk_sys),
    .sys_rst(sys_rst), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_si(spi_si),
    .spi_so(spi_so), .spi_so_oe(spi_so_oe), .wp_n(wp_n), .array_busy(array_busy),
    .param_load(param_load), .param_in(param_in), .wrap_in(wrap_in),
    .status_word(status_word), .write_enable_latch(write_enable_latch),
    .cycle_in_progress(cycle_in_progress), .block_protect_field(block_protect_field),
    .status_protect_bit(status_protect_bit), .deep_sleep(deep_sleep), .standby(standby),
    .read_parameter_bits(read_parameter_bits), .wrap_setting_bits(wrap_setting_bits),
    .soft_reset_pulse(soft_reset_pulse));
  fspd_host_model i_fspd_host_model (.spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
    .spi_si(spi_si), .spi_so(spi_so));
  task automatic xf(input logic [31:0] t, input int nb);
    // Start off the clock edges so no pin change races the synchroniser
    @(negedge clk_sys);
    #1;
    i_fspd_host_model.frame({t, 32'h0000_0000}, nb, rx);
  endtask
  task automatic op(input logic [7:0] o);
    xf({o, 24'h00_0000}, 8);
  endtask
  // enable then write, never both enables
  task automatic wr(input int s, input logic [7:0] v);
    op(OP_WEN);
    xf({WOP[s], v, 16'h0000}, 16);
  endtask
  task automatic wait_idle();
    int k;
    k = 0;
    while (cycle_in_progress !== 1'b0 && k < 5000) begin
      @(negedge clk_sys);
      k++;
    end
    if (k == 5000) begin
      `CHK("idle", 1'b0, cycle_in_progress)
      conclude();
    end
  endtask
  // Expected status after a write: fixed and live bits never taken
  function automatic logic [23:0] upd(logic [23:0] s, int n, logic [7:0] v);
    logic [23:0] m;
    m = 24'h00_00FF << (n * 8);
    return (s & ~m) | ((24'(v) << (n * 8)) & m & ~SR_FIXED);
  endfunction
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    void'($urandom(30));
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys) sys_rst = 1'b0;
    repeat (10) @(negedge clk_sys);
    `CHK("status", 24'h00_0000, status_word)
    `CHK("standby", 1'b1, standby)
    xf({OP_WR_S0, 8'hFC, 16'h0000}, 16);
    `CHK("no latch", 24'h00_0000, status_word)
    for (int s = 0; s < 3; s++) begin
      d = (s == 2) ? 8'hFF : (8'($urandom) | 8'h84);
      wr(s, d);
      xf({OP_RD_S0, 24'h00_0000}, 24);
      `CHK("busy bits", 4'hF, {rx[9:8], rx[1:0]})
      wait_idle();
      `CHK("latch end", 1'b0, write_enable_latch)
      sr = upd(sr, s, d);
      for (int r = 0; r < 3; r++) begin
        xf({ROP[r], 24'h00_0000}, 16);
        `CHK("read", sr[r*8+:8], rx[7:0])
      end
    end
    `CHK("bp", sr[6:2], block_protect_field)
    `CHK("srp", sr[7], status_protect_bit)
    $display("test writes done");
    op(OP_WEN);
    xf({OP_WR_S0, 24'h00_0000}, 12);
    `CHK("partial", sr[23:2], status_word[23:2])
    @(negedge clk_sys) wp_n = 1'b0;
    wr(0, 8'h00);
    `CHK("protected", sr[23:2], status_word[23:2])
    @(negedge clk_sys) wp_n = 1'b1;
    @(negedge clk_sys) array_busy = 1'b1;
    op(OP_SLEEP);
    `CHK("stby busy", 1'b0, standby)
    repeat (700) @(negedge clk_sys);
    `CHK("busy sleep", 1'b0, deep_sleep)
    @(negedge clk_sys) array_busy = 1'b0;
    xf({OP_WAKE, 24'h00_0000}, 48);
    `CHK("id", {DEV_ID, DEV_ID}, rx[15:0])
    d = 8'($urandom);
    wr(1, d);
    xf({OP_WAKE, 24'h00_0000}, 48);
    `CHK("id busy", 16'h0000, rx[15:0])
    wait_idle();
    sr = upd(sr, 1, d);
    $display("test protect done");
    xf({OP_SLEEP, 24'h00_0000}, 9);
    repeat (700) @(negedge clk_sys);
    `CHK("long frame", 1'b0, deep_sleep)
    op(OP_SLEEP);
    repeat (450) @(negedge clk_sys);
    `CHK("early", 1'b0, deep_sleep)
    repeat (200) @(negedge clk_sys);
    `CHK("asleep", 1'b1, deep_sleep)
    wr(0, 8'h00);
    `CHK("asleep wr", sr, status_word)
    xf({OP_RD_S0, 24'h00_0000}, 16);
    `CHK("asleep rd", 8'h00, rx[7:0])
    op(OP_WAKE);
    `CHK("woken", 1'b0, deep_sleep)
    op(OP_WEN);
    `CHK("lockout", 1'b0, write_enable_latch)
    repeat (700) @(negedge clk_sys);
    op(OP_WEN);
    `CHK("after wake", 1'b1, write_enable_latch)
    $display("test sleep done");
    @(negedge clk_sys) begin
      param_load = 1'b1;
      param_in = 8'($urandom) | 8'h01;
      wrap_in = 3'($urandom);
    end
    @(negedge clk_sys) param_load = 1'b0;
    op(OP_RST_EN);
    xf({OP_RD_S0, 24'h00_0000}, 16);
    op(OP_RST);
    `CHK("disarmed", 0, rst_seen)
    op(OP_RST_EN);
    op(OP_RST);
    `CHK("pulse", 1, rst_seen)
    `CHK("rst clr", 12'h000, {write_enable_latch, read_parameter_bits, wrap_setting_bits})
    op(OP_WEN);
    `CHK("recovery", 1'b0, write_enable_latch)
    repeat (500) @(negedge clk_sys);
    op(OP_VWREN);
    d = ~sr[15:8];
    xf({OP_WR_S1, d, 16'h0000}, 16);
    `CHK("volatile", upd(sr, 1, d), status_word)
    `CHK("no cycle", 1'b0, cycle_in_progress)
    op(OP_SLEEP);
    repeat (700) @(negedge clk_sys);
    op(OP_RST_EN);
    op(OP_RST);
    `CHK("rst wakes", 1'b0, deep_sleep)
    `CHK("rst vol", sr, status_word)
    $display("test reset done");
    conclude();
  end
endmodule
bind fspd_cmd_core fspd_cmd_core_assertions #(.WRT_CYC(WRT_CYC)) i_chk (.clk_sys(clk_sys),
  .sys_rst(sys_rst), .spi_cs_n(spi_cs_n), .spi_so(spi_so), .spi_so_oe(spi_so_oe),
  .status_word(status_word), .write_enable_latch(write_enable_latch),
  .cycle_in_progress(cycle_in_progress), .deep_sleep(deep_sleep), .standby(standby),
  .read_parameter_bits(read_parameter_bits), .wrap_setting_bits(wrap_setting_bits),
  .soft_reset_pulse(soft_reset_pulse));
`default_nettype wire

/* test/fspd_host_model.sv */
`default_nettype none
module fspd_host_model (
  output logic spi_sclk,
  output logic spi_cs_n,
  output logic spi_si,
  input wire logic spi_so
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_si = 1'b0;
  end
  // Released data line wanders so a stale bit is never trusted
  always #20 if (spi_cs_n) spi_si = ~spi_si;
  // One frame; the caller keeps frames whole bytes except on purpose
  // msb first, sample rising
  task automatic frame(input logic [63:0] tx, input int nb, output logic [63:0] rx);
    rx = 64'h0000_0000_0000_0000;
    spi_cs_n = 1'b0;
    for (int i = 0; i < nb; i++) begin
      spi_si = tx[63 - i];
      #62.5 spi_sclk = 1'b1;
      rx = {rx[62:0], spi_so};
      #62.5 spi_sclk = 1'b0;
    end
    #62.5 spi_cs_n = 1'b1;
    // Clock stands still and select stays high between frames
    #250;
  endtask
endmodule
`default_nettype wire
